// file: logic/gptu_pkg.sv
package gptu_pkg;

  // ==========================================================
  // Geometry
  localparam int GPTU_NUM_TIMERS = 5;
  localparam int GPTU_TW = 16;

  // ==========================================================
  // Timer indices
  localparam int IX_AUX_A = 0; // first_aux_timer_a
  localparam int IX_CORE1 = 1; // first_core_timer
  localparam int IX_AUX_B = 2; // first_aux_timer_b
  localparam int IX_AUX2 = 3; // second_aux_timer
  localparam int IX_CORE2 = 4; // second_core_timer

  // ==========================================================
  // Register word indices, byte address is four times the index
  localparam logic [3:0] REG_CTL0 = 4'h0; // controls 0..4 at 0x00..0x10
  localparam logic [3:0] REG_VAL0 = 4'h5; // values 0..4 at 0x14..0x24
  localparam logic [3:0] REG_CAPTURE_RELOAD_REGISTER = 4'hA; // 0x28
  localparam logic [3:0] REG_FLAGS = 4'hB; // 0x2C, write one to clear
  localparam logic [3:0] REG_LAST = 4'hB;

  // ==========================================================
  // Control field positions
  localparam int CTL_RUN = 0;
  localparam int CTL_MODE = 1; // two bits
  localparam int CTL_DDN = 3; // software direction, 1 = down
  localparam int CTL_DEXT = 4; // direction from pin
  localparam int CTL_PRE = 5; // three bits, prescale exponent
  localparam int CTL_AFN = 8; // two bits, aux function / bit 8,9 second module
  localparam int CTL_RLR = 10; // reload on latch rising / capture source low
  localparam int CTL_RLF = 11; // reload on latch falling / capture source high
  localparam int CTL_GLVL = 12; // active gate level
  localparam int CTL_RLP = 13; // reload on pin rising edge

  // Modes
  typedef enum logic [1:0] {
    GPTU_TIMER = 2'b00,
    GPTU_GATED = 2'b01,
    GPTU_COUNTER = 2'b10,
    GPTU_INCR = 2'b11
  } gptu_mode_e;

  // Aux functions of the first module
  localparam logic [1:0] AFN_NORMAL = 2'h0;
  localparam logic [1:0] AFN_CAPTURE = 2'h1;
  localparam logic [1:0] AFN_RELOAD = 2'h2;
  localparam logic [1:0] AFN_LATCH = 2'h3;

  // Base tick shifts: 4 and 2 system clocks
  localparam logic [3:0] SH_MOD1 = 4'h2;
  localparam logic [3:0] SH_MOD2 = 4'h1;

  // Flag bits
  localparam int FL_CAP_A = 5;
  localparam int FL_CAP_B = 6;
  localparam int FL_CAPTURE_RELOAD_REGISTER = 7;

  // ==========================================================
  // State
  typedef struct packed {
    logic [4:0][15:0] t;
    logic [4:0][15:0] ctl;
    logic [15:0] pre;
    logic [15:0] capture_reload_register;
    logic [7:0] flags;
    logic tl1;
    logic tl2;
    logic [4:0] sp;
    logic [4:0] sd;
    logic scp;
    logic sci;
    logic scd;
    logic ovf_out;
    logic [31:0] rdata;
  } gptu_state_s;

  localparam gptu_state_s GPTU_STATE_RST = '0;

endpackage

// file: logic/gptu_top.sv
`timescale 1ns/1ps
// Behaviour
// RQ1 - five 16-bit timers in two modules
// RQ2 - timers run alone or chained in module
// RQ3 - first module modes: timer, gated, counter, incremental
// RQ4 - timer mode counts prescaled system clock
// RQ5 - counter mode counts input pin events
// RQ6 - gated mode counts while gate level active
// RQ7 - first module resolution four clocks
// RQ8 - direction from software bit or pin
// RQ9 - incremental mode tracks quadrature A/B position
// RQ10 - core toggle latch flips on wrap
// RQ11 - aux timers may count core latch
// RQ12 - capture/reload aux timer stops counting
// RQ13 - capture copies core value on pin
// RQ14 - reload core on pin or latch edge
// RQ15 - dual reload gives free-running PWM
// RQ16 - second module resolution two clocks
// RQ17 - second timers: prescaler or pin, direction
// RQ18 - second core latch flips, clocks aux
// RQ19 - second core wraps clock others, reload
// RQ20 - capture pin stores aux, optional clear
// RQ21 - capture trigger from core pins too
// RQ22 - wrap and capture flags, software clearable
module gptu_top (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [gptu_pkg::GPTU_NUM_TIMERS-1:0] timer_input_pin_i,
  input wire logic [gptu_pkg::GPTU_NUM_TIMERS-1:0] direction_input_pin_i,
  input wire logic capture_input_pin_i,
  output logic core_toggle_output_o,
  output logic second_core_toggle_output_o,
  output logic other_compare_unit_timers_o
);
  import gptu_pkg::*;

  // ==========================================================
  // Helpers
  // Prescaler tick every 2^sh clocks
  function automatic logic gptu_tick(input logic [15:0] cnt, input logic [3:0] sh);
    logic [15:0] m;
    m = (16'h0001 << sh) - 16'h0001;
    return (cnt & m) == m;
  endfunction

  // Step value, bit 16 flags wrap
  function automatic logic [16:0] gptu_step(input logic [15:0] v, input logic dn);
    logic w;
    w = dn ? (v == 16'h0000) : (v == 16'hFFFF);
    return {w, dn ? v - 16'h0001 : v + 16'h0001};
  endfunction

  // Address lies on a mapped word
  function automatic logic gptu_mapped(input logic [31:0] a);
    return (a[1:0] == 2'h0) && (a[31:6] == 26'h0000000) && (a[5:2] <= REG_LAST);
  endfunction

  gptu_state_s r;
  gptu_state_s next_r;

  logic wr;
  logic [3:0] widx;
  logic b1;
  logic b2;
  logic [2:0] inc;
  logic [2:0] dn;
  logic [2:0] ein;
  logic [16:0] st;
  logic ovf1;
  logic ovf2;
  logic rl_hit;
  logic [15:0] rl_val;
  logic [1:0] cap1;
  logic cap2;
  logic inc5;
  logic dn5;
  logic inc6;
  logic dn6;
  logic [7:0] fset;

  // ==========================================================
  // APB handshake, zero wait states
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !gptu_mapped(paddr_i);
  assign wr = psel_i && penable_i && pwrite_i && gptu_mapped(paddr_i);
  assign widx = paddr_i[5:2];
  assign prdata_o = r.rdata;
  assign core_toggle_output_o = r.tl1;
  assign second_core_toggle_output_o = r.tl2;
  assign other_compare_unit_timers_o = r.ovf_out;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_r = r;
    inc = '0;
    dn = '0;
    ein = '0;
    st = '0;
    ovf1 = 1'b0;
    ovf2 = 1'b0;
    rl_hit = 1'b0;
    rl_val = '0;
    cap1 = '0;
    cap2 = 1'b0;
    inc5 = 1'b0;
    dn5 = 1'b0;
    inc6 = 1'b0;
    dn6 = 1'b0;
    fset = '0;
    next_r.pre = r.pre + 16'h0001;
    // Pins sampled on module base ticks
    b1 = gptu_tick(r.pre, SH_MOD1); // RQ7
    b2 = gptu_tick(r.pre, SH_MOD2); // RQ16

    // First module count enables and directions
    for (int i = 0; i < 3; i++)
    begin
      ein[i] = b1 && timer_input_pin_i[i] && !r.sp[i];
      dn[i] = r.ctl[i][CTL_DEXT] ? direction_input_pin_i[i] : r.ctl[i][CTL_DDN]; // RQ8
      case (gptu_mode_e'(r.ctl[i][CTL_MODE+:2])) // RQ3
        GPTU_TIMER:
          inc[i] = gptu_tick(r.pre, SH_MOD1 + {1'b0, r.ctl[i][CTL_PRE+:3]}); // RQ4
        GPTU_GATED:
          inc[i] = gptu_tick(r.pre, SH_MOD1 + {1'b0, r.ctl[i][CTL_PRE+:3]})
                   && (timer_input_pin_i[i] == r.ctl[i][CTL_GLVL]); // RQ6
        GPTU_COUNTER:
          inc[i] = ein[i]; // RQ5
        GPTU_INCR:
        begin
          // Quadrature decode on either input change
          inc[i] = b1 && ((timer_input_pin_i[i] != r.sp[i])
                   || (direction_input_pin_i[i] != r.sd[i])); // RQ9
          dn[i] = (timer_input_pin_i[i] != r.sp[i])
                  ? (timer_input_pin_i[i] == direction_input_pin_i[i])
                  : (timer_input_pin_i[i] != direction_input_pin_i[i]); // RQ9
        end
        default:
          inc[i] = 1'b0;
      endcase
      inc[i] = inc[i] && r.ctl[i][CTL_RUN];
    end

    // First core timer and its toggle latch
    if (inc[IX_CORE1])
    begin
      st = gptu_step(r.t[IX_CORE1], dn[IX_CORE1]);
      next_r.t[IX_CORE1] = st[15:0];
      ovf1 = st[16];
    end
    if (ovf1)
    begin
      next_r.tl1 = !r.tl1; // RQ10
      fset[IX_CORE1] = 1'b1; // RQ22
    end

    // First module aux timers
    for (int j = 0; j < 2; j++)
    begin
      int i;
      logic trig;
      i = 2 * j;
      trig = 1'b0;
      case (r.ctl[i][CTL_AFN+:2])
        AFN_CAPTURE:
        begin
          // Stopped; latches core value on pin rising edge
          if (ein[i]) // RQ12
          begin
            next_r.t[i] = r.t[IX_CORE1]; // RQ13
            cap1[j] = 1'b1;
          end
        end
        AFN_RELOAD:
        begin
          // Stopped; loads core on selected latch edge or pin
          trig = (r.ctl[i][CTL_RLR] && ovf1 && !r.tl1)
                 || (r.ctl[i][CTL_RLF] && ovf1 && r.tl1)
                 || (r.ctl[i][CTL_RLP] && ein[i]); // RQ14
          if (trig) // RQ15
          begin
            next_r.t[IX_CORE1] = r.t[i]; // RQ14
            rl_hit = 1'b1;
            rl_val = r.t[i];
          end
        end
        default:
        begin
          // Latch function counts core latch transitions
          if (r.ctl[i][CTL_AFN+:2] == AFN_LATCH)
          begin
            inc[i] = ovf1 && r.ctl[i][CTL_RUN]; // RQ11
          end
          if (inc[i]) // RQ2
          begin
            st = gptu_step(r.t[i], dn[i]);
            next_r.t[i] = st[15:0];
            fset[i] = st[16]; // RQ22
          end
        end
      endcase
    end
    fset[FL_CAP_A] = cap1[0]; // RQ22
    fset[FL_CAP_B] = cap1[1]; // RQ22

    // Second module core timer
    dn6 = r.ctl[IX_CORE2][CTL_DEXT] ? direction_input_pin_i[IX_CORE2]
          : r.ctl[IX_CORE2][CTL_DDN]; // RQ17
    inc6 = (r.ctl[IX_CORE2][CTL_MODE+:2] == GPTU_COUNTER)
           ? (b2 && timer_input_pin_i[IX_CORE2] && !r.sp[IX_CORE2])
           : gptu_tick(r.pre, SH_MOD2 + {1'b0, r.ctl[IX_CORE2][CTL_PRE+:3]}); // RQ17
    if (inc6 && r.ctl[IX_CORE2][CTL_RUN])
    begin
      st = gptu_step(r.t[IX_CORE2], dn6);
      next_r.t[IX_CORE2] = st[15:0];
      ovf2 = st[16];
    end
    if (ovf2)
    begin
      next_r.tl2 = !r.tl2; // RQ18
      fset[IX_CORE2] = 1'b1; // RQ22
      if (r.ctl[IX_CORE2][CTL_AFN+1])
      begin
        next_r.t[IX_CORE2] = r.capture_reload_register; // RQ19
      end
    end
    next_r.ovf_out = ovf2; // RQ19

    // Second module aux timer, prescaler, pin or core latch
    dn5 = r.ctl[IX_AUX2][CTL_DEXT] ? direction_input_pin_i[IX_AUX2]
          : r.ctl[IX_AUX2][CTL_DDN]; // RQ17
    if (r.ctl[IX_AUX2][CTL_AFN])
    begin
      inc5 = ovf2; // RQ18
    end
    else if (r.ctl[IX_AUX2][CTL_MODE+:2] == GPTU_COUNTER)
    begin
      inc5 = b2 && timer_input_pin_i[IX_AUX2] && !r.sp[IX_AUX2]; // RQ17
    end
    else
    begin
      inc5 = gptu_tick(r.pre, SH_MOD2 + {1'b0, r.ctl[IX_AUX2][CTL_PRE+:3]}); // RQ17
    end
    if (inc5 && r.ctl[IX_AUX2][CTL_RUN])
    begin
      st = gptu_step(r.t[IX_AUX2], dn5);
      next_r.t[IX_AUX2] = st[15:0];
      fset[IX_AUX2] = st[16]; // RQ22
    end

    // Capture into the capture/reload register
    case (r.ctl[IX_AUX2][CTL_RLR+:2])
      2'h0: cap2 = b2 && capture_input_pin_i && !r.scp; // RQ20
      2'h1: cap2 = b2 && (timer_input_pin_i[IX_CORE1] != r.sci); // RQ21
      2'h2: cap2 = b2 && (direction_input_pin_i[IX_CORE1] != r.scd); // RQ21
      default: cap2 = b2 && ((timer_input_pin_i[IX_CORE1] != r.sci)
                      || (direction_input_pin_i[IX_CORE1] != r.scd)); // RQ21
    endcase
    if (cap2)
    begin
      next_r.capture_reload_register = r.t[IX_AUX2]; // RQ20
      fset[FL_CAPTURE_RELOAD_REGISTER] = 1'b1; // RQ22
      if (r.ctl[IX_AUX2][CTL_AFN+1])
      begin
        next_r.t[IX_AUX2] = 16'h0000; // RQ20
      end
    end

    // Pin samples on base ticks
    if (b1)
    begin
      next_r.sp[2:0] = timer_input_pin_i[2:0];
      next_r.sd[2:0] = direction_input_pin_i[2:0];
    end
    if (b2)
    begin
      next_r.sp[4:3] = timer_input_pin_i[4:3];
      next_r.sd[4:3] = direction_input_pin_i[4:3];
      next_r.scp = capture_input_pin_i;
      next_r.sci = timer_input_pin_i[IX_CORE1];
      next_r.scd = direction_input_pin_i[IX_CORE1];
    end

    // Software writes, flags set wins over clear
    next_r.flags = r.flags | fset;
    if (wr)
    begin
      if (widx < REG_VAL0)
      begin
        next_r.ctl[widx[2:0]] = pwdata_i[15:0];
      end
      else if (widx < REG_CAPTURE_RELOAD_REGISTER)
      begin
        next_r.t[3'(widx - REG_VAL0)] = pwdata_i[15:0]; // RQ1
      end
      else if (widx == REG_CAPTURE_RELOAD_REGISTER)
      begin
        next_r.capture_reload_register = pwdata_i[15:0];
      end
      else
      begin
        next_r.flags = (r.flags & ~pwdata_i[7:0]) | fset; // RQ22
      end
    end

    // Read data captured in setup phase
    if (psel_i && !penable_i)
    begin
      next_r.rdata = 32'h00000000;
      if (gptu_mapped(paddr_i))
      begin
        if (widx < REG_VAL0)
        begin
          next_r.rdata[15:0] = r.ctl[widx[2:0]];
        end
        else if (widx < REG_CAPTURE_RELOAD_REGISTER)
        begin
          next_r.rdata[15:0] = r.t[3'(widx - REG_VAL0)];
        end
        else if (widx == REG_CAPTURE_RELOAD_REGISTER)
        begin
          next_r.rdata[15:0] = r.capture_reload_register;
        end
        else
        begin
          next_r.rdata[7:0] = r.flags;
        end
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      r <= GPTU_STATE_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Checks
  AST_TICK4: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RQ7
    b1 |=> !b1 [*3])
    else $error("first module base tick faster than four clocks");

  AST_TICK2: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RQ16
    b2 |=> !b2 ##1 b2)
    else $error("second module base tick not every two clocks");

  AST_LATCH1: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RQ10
    ovf1 |=> core_toggle_output_o != $past(core_toggle_output_o))
    else $error("core toggle latch missed a wrap");

  AST_LATCH2: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RQ18
    ovf2 |=> second_core_toggle_output_o != $past(second_core_toggle_output_o))
    else $error("second core toggle latch missed a wrap");

  AST_STOPPED: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RQ12
    (r.ctl[IX_AUX_A][CTL_AFN+:2] == AFN_CAPTURE && !cap1[0] && !wr)
    |=> $stable(r.t[IX_AUX_A]))
    else $error("capture-mode aux timer changed without capture");

  AST_CAPTURE: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RQ13
    (cap1[0] && !wr) |=> r.t[IX_AUX_A] == $past(r.t[IX_CORE1]))
    else $error("aux capture did not take core value");

  AST_RELOAD: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RQ14
    (rl_hit && !wr) |=> r.t[IX_CORE1] == $past(rl_val))
    else $error("core reload did not take aux value");

  AST_WRAPOUT: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RQ19
    ovf2 |=> other_compare_unit_timers_o ##1 (other_compare_unit_timers_o == $past(ovf2)))
    else $error("second core wrap pulse not forwarded");

  AST_CAPTURE_RELOAD_REGISTER: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RQ20
    (cap2 && !wr) |=> r.capture_reload_register == $past(r.t[IX_AUX2]))
    else $error("capture register did not store aux value");

  AST_FLAG: assert property (@(posedge clock_i) disable iff (!reset_n_i) // RQ22
    ovf1 |=> r.flags[IX_CORE1])
    else $error("core wrap flag lost");

endmodule // gptu_top

// file: sim/gptu_pins_model.sv
`timescale 1ns/1ps
// Quadrature sensor on the far side, A/B from step requests
module gptu_pins_model (
  input wire logic clock_i,
  input wire logic step_i,
  input wire logic down_i,
  output logic a_o,
  output logic b_o
);
  logic [1:0] ph = 2'h0;

  // ==========================================
  // Sensor phase, one quarter per step
  always_ff @(posedge clock_i)
  begin
    if (step_i)
      ph <= down_i ? ph - 2'h1 : ph + 2'h1;
  end

  // Gray-coded outputs, one line changes per step
  assign a_o = ph[1] ^ ph[0];
  assign b_o = ph[1];
endmodule // gptu_pins_model

// file: sim/gptu_top_tb_top.sv
`timescale 1ns/1ps
// Bench for the timer unit over APB
module gptu_top_tb_top;
  import gptu_pkg::*;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] ev = '0;
  logic [4:0] tdir = '0;
  logic step = 1'b0;
  logic sdown = 1'b0;
  logic qa;
  logic qb;
  logic tout1;
  logic tout2;
  logic ocu;
  logic [4:0] pin_in;
  logic [4:0] dir_in;
  logic [31:0] rd;
  logic [31:0] r0;
  logic err;
  int error_cnt = 0;
  int n_compared = 0;
  int ocu_cnt = 0;
  int hi = 0;

  // ==========================================
  // Clock, pins and instances
  always #2.5 clock_i = ~clock_i;
  assign pin_in = ev[4:0] ^ {3'h0, qa, 1'b0};
  assign dir_in = tdir ^ {3'h0, qb, 1'b0};

  gptu_top uut (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr),
    .timer_input_pin_i(pin_in),
    .direction_input_pin_i(dir_in),
    .capture_input_pin_i(ev[5]),
    .core_toggle_output_o(tout1),
    .second_core_toggle_output_o(tout2),
    .other_compare_unit_timers_o(ocu)
  );

  gptu_pins_model sensor (
    .clock_i(clock_i),
    .step_i(step),
    .down_i(sdown),
    .a_o(qa),
    .b_o(qb)
  );

  // Pulses towards the other compare unit, sampled mid-cycle where settled
  always @(negedge clock_i)
  begin
    if (ocu === 1'b1)
      ocu_cnt++;
  end

  // ==========================================
  // Tasks
  task automatic final_report;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_compared++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // One APB transfer, word index to byte address
  task automatic apb(input logic w, input logic [3:0] ix, input logic [15:0] wd);
    int k;
    begin
      @(posedge clock_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {26'h0, ix, 2'h0};
      pwdata <= {16'h0, wd};
      @(posedge clock_i);
      penable <= 1'b1;
      k = 0;
      do
      begin
        @(posedge clock_i);
        k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
        error_cnt++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Count advance of a value over w+3 clocks
  task automatic span(input logic [3:0] ix, input int w);
    begin
      apb(1'b0, ix, 16'h0);
      r0 = rd;
      repeat (w) @(posedge clock_i);
      apb(1'b0, ix, 16'h0);
      rd = {16'h0, rd[15:0] - r0[15:0]};
    end
  endtask

  task automatic pulse(input int i);
    begin
      @(posedge clock_i);
      ev[i] <= 1'b1;
      repeat (8) @(posedge clock_i);
      ev[i] <= 1'b0;
      repeat (8) @(posedge clock_i);
    end
  endtask

  task automatic qstep(input logic dn, input int n);
    repeat (n)
    begin
      @(posedge clock_i);
      step <= 1'b1;
      sdown <= dn;
      @(posedge clock_i);
      step <= 1'b0;
      repeat (8) @(posedge clock_i);
    end
  endtask

  // ==========================================
  // Tests
  initial
  begin
    repeat (10) @(posedge clock_i);
    reset_n_i <= 1'b1;
    apb(1'b0, 4'h1, 16'h0);
    chk(rd, 32'h0);
    apb(1'b0, 4'hC, 16'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Timer mode, up then down with prescale
    apb(1'b1, 4'h1, 16'h0001);
    span(4'h6, 61);
    chk(rd, 32'h10);
    apb(1'b1, 4'h1, 16'h0049);
    span(4'h6, 61);
    chk(rd, 32'hFFFC);
    // Core wrap, toggle latch and flag
    apb(1'b1, 4'h1, 16'h0);
    apb(1'b1, 4'hB, 16'h00FF);
    apb(1'b1, 4'h6, 16'hFFF8);
    apb(1'b1, 4'h1, 16'h0001);
    repeat (40) @(posedge clock_i);
    apb(1'b1, 4'h1, 16'h0);
    chk({31'h0, tout1}, 32'h1);
    apb(1'b0, 4'hB, 16'h0);
    chk(rd & 32'h2, 32'h2);
    apb(1'b1, 4'hB, 16'h0002);
    apb(1'b0, 4'hB, 16'h0);
    chk(rd & 32'h2, 32'h0);
    // Second core, direction from pin
    tdir[4] <= 1'b1;
    apb(1'b1, 4'h4, 16'h0011);
    span(4'h9, 37);
    chk(rd, 32'hFFEC);
    apb(1'b1, 4'h4, 16'h0);
    tdir[4] <= 1'b0;
    chk({31'h0, tout2}, 32'h1);
    chk(ocu_cnt, 32'h1);
    // Counter mode on pin events
    apb(1'b1, 4'h0, 16'h0005);
    repeat (5) pulse(0);
    apb(1'b0, 4'h5, 16'h0);
    chk(rd, 32'h5);
    // Gated mode, gate open then closed
    apb(1'b1, 4'h2, 16'h1003);
    ev[2] <= 1'b1;
    repeat (8) @(posedge clock_i);
    span(4'h7, 61);
    chk(rd, 32'h10);
    ev[2] <= 1'b0;
    repeat (8) @(posedge clock_i);
    span(4'h7, 61);
    chk(rd, 32'h0);
    // Incremental interface
    apb(1'b1, 4'h6, 16'h0);
    apb(1'b1, 4'h1, 16'h0007);
    qstep(1'b0, 6);
    apb(1'b0, 4'h6, 16'h0);
    chk(rd, 32'h6);
    qstep(1'b1, 2);
    apb(1'b0, 4'h6, 16'h0);
    chk(rd, 32'h4);
    // Capture of core into aux, aux stopped
    apb(1'b1, 4'h1, 16'h0);
    apb(1'b1, 4'h6, 16'h1234);
    apb(1'b1, 4'h0, 16'h0101);
    pulse(0);
    apb(1'b0, 4'h5, 16'h0);
    chk(rd, 32'h1234);
    repeat (40) @(posedge clock_i);
    apb(1'b0, 4'h5, 16'h0);
    chk(rd, 32'h1234);
    apb(1'b0, 4'hB, 16'h0);
    chk(rd & 32'h20, 32'h20);
    // Reload of core from aux on pin
    apb(1'b1, 4'h7, 16'h4321);
    apb(1'b1, 4'h2, 16'h2200);
    apb(1'b1, 4'h6, 16'h0);
    pulse(2);
    apb(1'b0, 4'h6, 16'h0);
    chk(rd, 32'h4321);
    // Capture register from pin, then from core input
    apb(1'b1, 4'h8, 16'h55AA);
    apb(1'b1, 4'h3, 16'h0200);
    pulse(5);
    apb(1'b0, 4'hA, 16'h0);
    chk(rd, 32'h55AA);
    apb(1'b0, 4'h8, 16'h0);
    chk(rd, 32'h0);
    apb(1'b1, 4'h3, 16'h0400);
    apb(1'b1, 4'h8, 16'h0077);
    pulse(1);
    apb(1'b0, 4'hA, 16'h0);
    chk(rd, 32'h0077);
    apb(1'b0, 4'hB, 16'h0);
    chk(rd & 32'h80, 32'h80);
    // Second core wrap reloads from capture register
    apb(1'b1, 4'h9, 16'hFFFE);
    apb(1'b1, 4'h4, 16'h0201);
    repeat (20) @(posedge clock_i);
    apb(1'b1, 4'h4, 16'h0);
    apb(1'b0, 4'h9, 16'h0);
    chk({31'h0, rd >= 32'h77 && rd <= 32'h90}, 32'h1);
    chk(ocu_cnt, 32'h2);
    chk({31'h0, tout2}, 32'h0);
    // Capture register from core direction pin
    apb(1'b1, 4'h3, 16'h0800);
    apb(1'b1, 4'h8, 16'h0099);
    tdir[1] <= 1'b1;
    repeat (8) @(posedge clock_i);
    apb(1'b0, 4'hA, 16'h0);
    chk(rd, 32'h0099);
    tdir[1] <= 1'b0;
    // Aux_a counts core latch wraps, aux_b reloads core on both edges
    apb(1'b1, 4'h7, 16'hFFFC);
    apb(1'b1, 4'h2, 16'h0E00);
    apb(1'b1, 4'h0, 16'h0301);
    apb(1'b1, 4'h6, 16'hFFFC);
    apb(1'b1, 4'h1, 16'h0001);
    span(4'h5, 157);
    chk(rd, 32'hA);
    // PWM from two reload values, high 16 and low 8 clocks
    apb(1'b1, 4'h1, 16'h0);
    apb(1'b1, 4'h0, 16'h0600);
    apb(1'b1, 4'h5, 16'hFFFC);
    apb(1'b1, 4'h2, 16'h0A00);
    apb(1'b1, 4'h7, 16'hFFFE);
    apb(1'b1, 4'h6, 16'hFFFE);
    apb(1'b1, 4'h1, 16'h0001);
    repeat (60) @(posedge clock_i);
    repeat (96)
    begin
      @(negedge clock_i);
      if (tout1 === 1'b1)
        hi++;
    end
    chk(hi, 32'h40);
    apb(1'b1, 4'h1, 16'h0);
    final_report();
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    final_report();
  end
endmodule // gptu_top_tb_top
